/* File: core/psl_regs.svh */
/*
 Timing counts, reset values and sizes for the PoE sideband LED and reset block.
 Assumes a 40 MHz system clock; every cycle count is derived from a time below.
*/
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

// =====================================================================
// Clock
`define PSL_CLK_MHZ          40

// =====================================================================
// LED chain
`define PSL_LED_PORTS        48
`define PSL_LEDS_PER_PORT    2
`define PSL_SCLK_HALF_NS     250
`define PSL_SCLK_HALF_CYC    ((`PSL_SCLK_HALF_NS * `PSL_CLK_MHZ + 999) / 1000)

// =====================================================================
// PSE hard reset
`define PSL_PSE_RST_NS       5000
`define PSL_PSE_RST_CYC      ((`PSL_PSE_RST_NS * `PSL_CLK_MHZ) / 1000)
`define PSL_HARD_RESET_N_RST 1'b0
`define PSL_MODE_STRAP_RST   1'b1

// =====================================================================
// Supply monitor
`define PSL_SUPPLY_RST       2'h0

`endif

/* File: core/psl_pkg.sv */
/*
 Types shared by the sideband LED and reset block.
 Assumes the constants of psl_regs.svh for sizes and counts.
*/
package psl_pkg;

   // =====================================================================
   // State machines
   typedef enum logic [2:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_GAP, SH_LATCH} psl_shift_e;
   typedef enum logic [0:0] {PR_HOLD, PR_RUN} psl_pse_e;

   // =====================================================================
   // Carriers
   typedef struct packed {
      logic sclk;
      logic sdata;
      logic latch;
   } psl_led_pins_s;

   typedef struct packed {
      logic one_good;
      logic two_good;
   } psl_supply_s;

endpackage

/* File: core/psl_led_shifter.sv */
/*
 Serial LED chain driver: shifts a bit string MSB first, then pulses latch.
 Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ps
module psl_led_shifter #(
   parameter int BITS = 96,
   parameter int HALF = 10
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    start,
   input  wire logic [BITS-1:0]         bits,
   output psl_pkg::psl_led_pins_s       pins,
   output logic                         busy
);
   localparam int TW = $clog2(HALF + 1);
   localparam int CW = $clog2(BITS + 1);
   localparam logic [TW-1:0] T_LOAD = TW'(HALF - 1);

   psl_pkg::psl_shift_e     state_reg, state_next;
   logic [BITS-1:0]         sh_reg, sh_next;
   logic [CW-1:0]           cnt_reg, cnt_next;
   logic [TW-1:0]           tmr_reg, tmr_next;
   psl_pkg::psl_led_pins_s  pins_reg, pins_next;
   logic                    busy_reg, busy_next;

   // =====================================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      sh_next    = sh_reg;
      cnt_next   = cnt_reg;
      tmr_next   = tmr_reg;
      pins_next  = pins_reg;
      busy_next  = busy_reg;
      unique case (state_reg)
         psl_pkg::SH_IDLE: begin
            if (start) begin
               sh_next         = bits;
               pins_next.sdata = bits[BITS-1]; // R5
               cnt_next        = CW'(BITS - 1); // R15
               tmr_next        = T_LOAD;
               busy_next       = 1'b1;
               state_next      = psl_pkg::SH_LOW;
            end
         end
         psl_pkg::SH_LOW: begin
            if (tmr_reg == '0) begin
               pins_next.sclk = 1'b1; // R2
               tmr_next       = T_LOAD;
               state_next     = psl_pkg::SH_HIGH;
            end else begin
               tmr_next = tmr_reg - 1'b1;
            end
         end
         psl_pkg::SH_HIGH: begin
            if (tmr_reg == '0) begin
               pins_next.sclk = 1'b0;
               tmr_next       = T_LOAD;
               if (cnt_reg == '0) begin
                  state_next = psl_pkg::SH_GAP;
               end else begin
                  sh_next         = {sh_reg[BITS-2:0], 1'b0}; // R5
                  pins_next.sdata = sh_reg[BITS-2]; // R6
                  cnt_next        = cnt_reg - 1'b1;
                  state_next      = psl_pkg::SH_LOW;
               end
            end else begin
               tmr_next = tmr_reg - 1'b1;
            end
         end
         psl_pkg::SH_GAP: begin
            if (tmr_reg == '0) begin
               pins_next.latch = 1'b1; // R3
               tmr_next        = T_LOAD;
               state_next      = psl_pkg::SH_LATCH;
            end else begin
               tmr_next = tmr_reg - 1'b1;
            end
         end
         psl_pkg::SH_LATCH: begin
            if (tmr_reg == '0) begin
               pins_next.latch = 1'b0;
               busy_next       = 1'b0;
               state_next      = psl_pkg::SH_IDLE;
            end else begin
               tmr_next = tmr_reg - 1'b1;
            end
         end
      endcase
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= psl_pkg::SH_IDLE;
         sh_reg    <= '0;
         cnt_reg   <= '0;
         tmr_reg   <= '0;
         pins_reg  <= '0;
         busy_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         sh_reg    <= sh_next;
         cnt_reg   <= cnt_next;
         tmr_reg   <= tmr_next;
         pins_reg  <= pins_next;
         busy_reg  <= busy_next;
      end
   end

   assign pins = pins_reg;
   assign busy = busy_reg;

   AST_BUSY_IN_CHAIN: assert property (@(posedge clk) disable iff (rst) // R15
      (pins_reg.sclk || pins_reg.latch) |-> busy_reg)
      else $error("LED pins active while shifter idle");

endmodule

/* File: core/psl_supply_monitor.sv */
/*
 Two-stage synchroniser and change detector for the two supply-good inputs.
 Assumes raw inputs may change at any time relative to the clock.
*/
`timescale 1ns/1ps
`include "psl_regs.svh"
module psl_supply_monitor (
   input  wire logic                clk,
   input  wire logic                rst,
   input  psl_pkg::psl_supply_s     raw,
   output psl_pkg::psl_supply_s     level,
   output logic                     changed
);
   psl_pkg::psl_supply_s  sync1_reg, sync2_reg, level_reg, level_next;
   logic                  chg_reg, chg_next;

   // =====================================================================
   // Next state
   always_comb begin
      level_next = sync2_reg;
      chg_next   = (sync2_reg != level_reg); // R16
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= `PSL_SUPPLY_RST;
         sync2_reg <= `PSL_SUPPLY_RST;
         level_reg <= `PSL_SUPPLY_RST;
         chg_reg   <= 1'b0;
      end else begin
         sync1_reg <= raw; // R16
         sync2_reg <= sync1_reg;
         level_reg <= level_next; // R9
         chg_reg   <= chg_next;
      end
   end

   assign level   = level_reg;
   assign changed = chg_reg;

endmodule

/* File: core/psl_sideband_top.sv */
/*
 PoE sideband block: LED shift chain, supply monitor, PSE hard reset and strap.
 Assumes synchronous user inputs on CLK, a 40 MHz clock and an active-high RST.
*/
// How it works
// R1: Two LED bits for each of 48 ports
// R2: Serial data and shift clock feed the chain
// R3: Latch pulses only after all bits shifted
// R4: Chain ordered from port 1 onward (external)
// R5: Bit string shifted most significant bit first
// R6: Each serial bit is one LED on/off
// R7: Clock, data and latch are outputs only
// R8: Two active-high supply-good inputs accepted
// R9: Supply levels watched continuously for changes
// R10: PSE reset on host command and system reset
// R11: PSE reset active low, output only
// R12: PSE samples strap at reset release (external)
// R13: Strap held high before and during release
// R14: Reference clock supplied by the system (external)
// R15: Exactly two bits per port, no clock during latch
// R16: Supplies double-synchronised, every change flagged
`timescale 1ns/1ps
`include "psl_regs.svh"
module psl_sideband_top #(
   parameter int PORTS    = `PSL_LED_PORTS,
   parameter int HALF_CYC = `PSL_SCLK_HALF_CYC,
   parameter int RST_CYC  = `PSL_PSE_RST_CYC
) (
   input  wire logic                                   CLK,
   input  wire logic                                   RST,
   input  wire logic [PORTS*`PSL_LEDS_PER_PORT-1:0]    LED_STATE,
   input  wire logic                                   LED_UPDATE,
   output logic                                        LED_BUSY,
   output logic                                        LED_SCLK,
   output logic                                        LED_SDATA,
   output logic                                        LED_LATCH,
   input  wire logic                                   SUPPLY_ONE_GOOD,
   input  wire logic                                   SUPPLY_TWO_GOOD,
   output logic                                        SUPPLY_ONE_OK,
   output logic                                        SUPPLY_TWO_OK,
   output logic                                        SUPPLY_CHANGE,
   input  wire logic                                   PSE_RESET_CMD,
   output logic                                        PSE_HARD_RESET_N,
   output logic                                        PSE_MODE_STRAP
);
   localparam int LED_BITS = PORTS * `PSL_LEDS_PER_PORT;
   localparam int RW       = $clog2(RST_CYC + 1);
   localparam logic [RW-1:0] R_LOAD = RW'(RST_CYC - 1);

   // =====================================================================
   // LED update request
   logic                    pend_reg, pend_next;
   logic                    start_reg, start_next;
   logic                    shift_busy;
   psl_pkg::psl_led_pins_s  led_pins;

   always_comb begin
      start_next = pend_reg && !shift_busy && !start_reg; // R3
      pend_next  = LED_UPDATE || (pend_reg && !start_next);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pend_reg  <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         pend_reg  <= pend_next;
         start_reg <= start_next;
      end
   end

   // =====================================================================
   // LED chain
   psl_led_shifter #(
      .BITS (LED_BITS),
      .HALF (HALF_CYC)
   ) u_shifter (
      .clk   (CLK),
      .rst   (RST),
      .start (start_reg),
      .bits  (LED_STATE), // R1
      .pins  (led_pins),
      .busy  (shift_busy)
   );

   assign LED_SCLK  = led_pins.sclk; // R7
   assign LED_SDATA = led_pins.sdata; // R7
   assign LED_LATCH = led_pins.latch; // R7
   assign LED_BUSY  = shift_busy;

   // =====================================================================
   // Supply monitor
   psl_pkg::psl_supply_s  sup_raw;
   psl_pkg::psl_supply_s  sup_level;

   assign sup_raw.one_good = SUPPLY_ONE_GOOD; // R8
   assign sup_raw.two_good = SUPPLY_TWO_GOOD; // R8

   psl_supply_monitor u_supply (
      .clk     (CLK),
      .rst     (RST),
      .raw     (sup_raw),
      .level   (sup_level),
      .changed (SUPPLY_CHANGE)
   );

   assign SUPPLY_ONE_OK = sup_level.one_good;
   assign SUPPLY_TWO_OK = sup_level.two_good;

   // =====================================================================
   // PSE hard reset and mode strap
   psl_pkg::psl_pse_e  pse_reg, pse_next;
   logic [RW-1:0]      rtmr_reg, rtmr_next;
   logic               hrst_n_reg, hrst_n_next;
   logic               strap_reg, strap_next;

   always_comb begin
      pse_next    = pse_reg;
      rtmr_next   = rtmr_reg;
      hrst_n_next = hrst_n_reg;
      strap_next  = 1'b1; // R13
      unique case (pse_reg)
         psl_pkg::PR_HOLD: begin
            if (rtmr_reg == '0) begin
               hrst_n_next = 1'b1; // R11
               pse_next    = psl_pkg::PR_RUN;
            end else begin
               rtmr_next = rtmr_reg - 1'b1;
            end
         end
         psl_pkg::PR_RUN: begin
            if (PSE_RESET_CMD) begin
               hrst_n_next = 1'b0; // R10
               rtmr_next   = R_LOAD;
               pse_next    = psl_pkg::PR_HOLD;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pse_reg    <= psl_pkg::PR_HOLD;
         rtmr_reg   <= R_LOAD;
         hrst_n_reg <= `PSL_HARD_RESET_N_RST; // R10
         strap_reg  <= `PSL_MODE_STRAP_RST; // R13
      end else begin
         pse_reg    <= pse_next;
         rtmr_reg   <= rtmr_next;
         hrst_n_reg <= hrst_n_next;
         strap_reg  <= strap_next;
      end
   end

   assign PSE_HARD_RESET_N = hrst_n_reg; // R11
   assign PSE_MODE_STRAP   = strap_reg;

   // =====================================================================
   // Assertion helpers
   localparam int BUSY_CYC = (LED_BITS + 1) * 2 * HALF_CYC;
   localparam int BW       = $clog2(BUSY_CYC + 1);

   logic [LED_BITS-1:0]  cap_reg;
   logic [7:0]           edge_cnt_reg;
   logic                 sclk_d_reg;
   logic [BW-1:0]        busy_cnt_reg;
   logic [RW-1:0]        rlow_cnt_reg;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cap_reg      <= '0;
         edge_cnt_reg <= '0;
         sclk_d_reg   <= 1'b0;
         busy_cnt_reg <= '0;
         rlow_cnt_reg <= '0;
      end else begin
         sclk_d_reg <= LED_SCLK;
         if (LED_BUSY) begin
            busy_cnt_reg <= busy_cnt_reg + BW'(1);
         end else begin
            busy_cnt_reg <= '0;
         end
         if (!PSE_HARD_RESET_N) begin
            rlow_cnt_reg <= rlow_cnt_reg + RW'(1);
         end else begin
            rlow_cnt_reg <= '0;
         end
         if (start_reg) begin
            cap_reg      <= LED_STATE;
            edge_cnt_reg <= '0;
         end else if (LED_SCLK && !sclk_d_reg) begin
            edge_cnt_reg <= edge_cnt_reg + 8'h01;
         end
      end
   end

   // =====================================================================
   // Assertions
   AST_NO_SCLK_IN_LATCH: assert property (@(posedge CLK) disable iff (RST) // R15
      LED_LATCH |-> !LED_SCLK)
      else $error("Shift clock high while latch asserted");

   AST_LATCH_AFTER_ALL: assert property (@(posedge CLK) disable iff (RST) // R3
      $rose(LED_LATCH) |-> edge_cnt_reg == 8'(LED_BITS))
      else $error("Latch before full bit string shifted");

   AST_LATCH_WIDTH: assert property (@(posedge CLK) disable iff (RST) // R3
      $rose(LED_LATCH) |-> ##9 LED_LATCH ##1 !LED_LATCH)
      else $error("Latch pulse width wrong");

   AST_BIT_ORDER: assert property (@(posedge CLK) disable iff (RST) // R5
      $rose(LED_SCLK) |-> LED_SDATA == cap_reg[LED_BITS-1-int'(edge_cnt_reg)])
      else $error("Serial bit out of order");

   AST_DATA_SETUP: assert property (@(posedge CLK) disable iff (RST) // R2
      $rose(LED_SCLK) |-> $stable(LED_SDATA))
      else $error("Serial data changed at clock rise");

   AST_SCLK_HALF: assert property (@(posedge CLK) disable iff (RST) // R2
      $rose(LED_SCLK) |-> LED_SCLK[*8] ##1 LED_SCLK ##1 LED_SCLK ##1 !LED_SCLK)
      else $error("Shift clock high phase wrong");

   AST_UPDATE_SERVED: assert property (@(posedge CLK) disable iff (RST) // R6
      (LED_UPDATE && !LED_BUSY && !pend_reg && !start_reg) |-> ##3 LED_BUSY)
      else $error("LED update not started");

   AST_CMD_RESET: assert property (@(posedge CLK) disable iff (RST) // R10
      (PSE_RESET_CMD && PSE_HARD_RESET_N) |=> !PSE_HARD_RESET_N)
      else $error("Host reset command did not reset PSE");

   AST_RESET_LENGTH: assert property (@(posedge CLK) disable iff (RST) // R10
      $fell(PSE_HARD_RESET_N) |-> ##199 !PSE_HARD_RESET_N ##1 PSE_HARD_RESET_N)
      else $error("PSE reset pulse length wrong");

   AST_STRAP_AT_RELEASE: assert property (@(posedge CLK) disable iff (RST) // R13
      $rose(PSE_HARD_RESET_N) |-> PSE_MODE_STRAP && $past(PSE_MODE_STRAP))
      else $error("Mode strap low at PSE reset release");

   AST_SUPPLY_FLAG: assert property (@(posedge CLK) disable iff (RST) // R16
      SUPPLY_CHANGE == ({SUPPLY_ONE_OK, SUPPLY_TWO_OK} != $past({SUPPLY_ONE_OK, SUPPLY_TWO_OK})))
      else $error("Supply change flag mismatch");

   AST_SUPPLY_FOLLOW: assert property (@(posedge CLK) disable iff (RST) // R9
      SUPPLY_ONE_GOOD[*4] |-> SUPPLY_ONE_OK)
      else $error("Supply one level not followed");

   AST_SUPPLY_TWO_FOLLOW: assert property (@(posedge CLK) disable iff (RST) // R8
      (!SUPPLY_TWO_GOOD)[*4] |-> !SUPPLY_TWO_OK)
      else $error("Supply two level not followed");

   AST_SUPPLY_ONE_LOW: assert property (@(posedge CLK) disable iff (RST) // R9
      (!SUPPLY_ONE_GOOD)[*4] |-> !SUPPLY_ONE_OK)
      else $error("Supply one loss not followed");

   AST_SUPPLY_TWO_HIGH: assert property (@(posedge CLK) disable iff (RST) // R8
      SUPPLY_TWO_GOOD[*4] |-> SUPPLY_TWO_OK)
      else $error("Supply two return not followed");

   AST_SCLK_FIRST: assert property (@(posedge CLK) disable iff (RST) // R2
      $rose(LED_BUSY) |-> (!LED_SCLK)[*8] ##1 !LED_SCLK ##1 !LED_SCLK ##1 LED_SCLK)
      else $error("First shift clock rise mistimed");

   AST_SCLK_LOW: assert property (@(posedge CLK) disable iff (RST) // R2
      $fell(LED_SCLK) |-> (!LED_SCLK)[*8] ##1 !LED_SCLK ##1 !LED_SCLK ##1 (LED_SCLK || LED_LATCH))
      else $error("Shift clock low phase wrong");

   AST_SDATA_MOVES: assert property (@(posedge CLK) disable iff (RST) // R5
      $changed(LED_SDATA) |-> $fell(LED_SCLK) || $rose(LED_BUSY))
      else $error("Serial data moved outside a clock fall");

   AST_SDATA_HELD: assert property (@(posedge CLK) disable iff (RST) // R6
      LED_SCLK |-> $stable(LED_SDATA))
      else $error("Serial data moved while shift clock high");

   AST_LATCH_ENDS: assert property (@(posedge CLK) disable iff (RST) // R3
      $fell(LED_LATCH) |-> !LED_BUSY)
      else $error("Busy outlived the latch pulse");

   AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (RST) // R15
      !LED_BUSY |-> !LED_SCLK && !LED_LATCH)
      else $error("Chain pins active while idle");

   AST_BUSY_FRAME: assert property (@(posedge CLK) disable iff (RST) // R15
      $fell(LED_BUSY) |-> busy_cnt_reg == BW'(BUSY_CYC))
      else $error("Frame length wrong");

   AST_BUSY_BOUND: assert property (@(posedge CLK) disable iff (RST) // R15
      busy_cnt_reg <= BW'(BUSY_CYC))
      else $error("Frame ran too long");

   AST_PEND_SERVED: assert property (@(posedge CLK) disable iff (RST) // R3
      ($fell(LED_BUSY) && pend_reg) |-> ##2 LED_BUSY)
      else $error("Queued LED update not started");

   AST_RESET_LOW_COUNT: assert property (@(posedge CLK) disable iff (RST) // R11
      $rose(PSE_HARD_RESET_N) |-> rlow_cnt_reg == RW'(RST_CYC))
      else $error("PSE reset low time wrong");

   AST_RESET_BOUND: assert property (@(posedge CLK) disable iff (RST) // R10
      rlow_cnt_reg <= RW'(RST_CYC))
      else $error("PSE reset held too long");

   AST_STRAP_HIGH: assert property (@(posedge CLK) disable iff (RST) // R13
      PSE_MODE_STRAP)
      else $error("Mode strap not high");

endmodule

/* File: bench/psl_chain_model.sv */
/*
 Far-side model: daisy-chained LED shift registers with latches, and the PSE devices.
 Assumes registered SCLK, SDATA and LATCH from the block and one PSE reset line.
*/
`timescale 1ns/1ps
module psl_chain_model #(
   parameter int BITS = 96
) (
   input  wire logic              sclk,
   input  wire logic              sdata,
   input  wire logic              latch,
   input  wire logic              hard_reset_n,
   input  wire logic              strap,
   output logic [BITS-1:0]        led_out,
   output int                     latch_count,
   output int                     bits_at_latch,
   output int                     clk_in_latch,
   output logic                   manual_mode
);
   // ====================================================================
   // Shift chain: first bit travels farthest, last bit sits at port 1
   logic [BITS-1:0] stage;
   int              shifted;

   initial begin
      stage = '0;
      led_out = '0;
      shifted = 0;
      latch_count = 0;
      bits_at_latch = 0;
      clk_in_latch = 0;
      manual_mode = 1'b0;
   end

   always @(posedge sclk) begin
      stage = {stage[BITS-2:0], sdata};
      shifted++;
      if (latch) begin
         clk_in_latch++;
      end
   end

   // ====================================================================
   // Latches: all stages copied at once
   always @(posedge latch) begin
      led_out = stage;
      bits_at_latch = shifted;
      shifted = 0;
      latch_count++;
   end

   // ====================================================================
   // PSE devices: mode taken from the strap at reset release
   always @(posedge hard_reset_n) begin
      manual_mode = strap;
   end

   // Mode forgotten while held in reset
   always @(negedge hard_reset_n) begin
      manual_mode = 1'b0;
   end
endmodule

/* File: bench/psl_sideband_top_tb.sv */
/*
 Self-checking bench for the sideband LED, supply monitor and PSE reset block.
 Assumes default parameters, a 40 MHz clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`include "psl_regs.svh"
module psl_sideband_top_tb;
   localparam int NB = `PSL_LED_PORTS * `PSL_LEDS_PER_PORT;

   logic          clk;
   logic          rst;
   logic [NB-1:0] led_state;
   logic          led_update;
   logic          led_busy;
   logic          led_sclk;
   logic          led_sdata;
   logic          led_latch;
   logic          s1_in;
   logic          s2_in;
   logic          s1_ok;
   logic          s2_ok;
   logic          s_change;
   logic          pse_cmd;
   logic          pse_rst_n;
   logic          pse_strap;
   logic [NB-1:0] led_out;
   int            latch_count;
   int            bits_at_latch;
   int            clk_in_latch;
   logic          manual_mode;
   int            fail_count;
   int            comparisons;

   psl_sideband_top uut (
      .CLK(clk), .RST(rst), .LED_STATE(led_state), .LED_UPDATE(led_update),
      .LED_BUSY(led_busy), .LED_SCLK(led_sclk), .LED_SDATA(led_sdata), .LED_LATCH(led_latch),
      .SUPPLY_ONE_GOOD(s1_in), .SUPPLY_TWO_GOOD(s2_in), .SUPPLY_ONE_OK(s1_ok),
      .SUPPLY_TWO_OK(s2_ok), .SUPPLY_CHANGE(s_change), .PSE_RESET_CMD(pse_cmd),
      .PSE_HARD_RESET_N(pse_rst_n), .PSE_MODE_STRAP(pse_strap)
   );

   psl_chain_model #(.BITS(NB)) partner (
      .sclk(led_sclk), .sdata(led_sdata), .latch(led_latch), .hard_reset_n(pse_rst_n),
      .strap(pse_strap), .led_out(led_out), .latch_count(latch_count),
      .bits_at_latch(bits_at_latch), .clk_in_latch(clk_in_latch), .manual_mode(manual_mode)
   );

   // ====================================================================
   // Clock, comparison and closing
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [NB-1:0] got, input logic [NB-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   task automatic end_sim;
      if (fail_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ====================================================================
   // Reset values and PSE release with strap high
   task automatic t_reset;
      int n;
      rst = 1'b1;
      repeat (6) @(negedge clk);
      chk(pse_rst_n, 1'b0);
      chk(pse_strap, 1'b1);
      chk({led_sclk, led_sdata, led_latch, led_busy}, 4'h0);
      rst = 1'b0;
      n = 0;
      while (pse_rst_n !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(n, `PSL_PSE_RST_CYC);
      chk(manual_mode, 1'b1);
   endtask

   // ====================================================================
   // Host reset command, and a command while in reset is ignored
   task automatic t_pse_cmd;
      int n;
      pse_cmd = 1'b1;
      @(negedge clk);
      pse_cmd = 1'b0;
      chk(pse_rst_n, 1'b0);
      chk(manual_mode, 1'b0);
      repeat (50) @(negedge clk);
      pse_cmd = 1'b1;
      @(negedge clk);
      pse_cmd = 1'b0;
      n = 51;
      while (pse_rst_n !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(n, `PSL_PSE_RST_CYC);
      chk(manual_mode, 1'b1);
   endtask

   // ====================================================================
   // Supply change: three cycles to the level, one-cycle change flag
   task automatic t_supply(input logic a, input logic b);
      int n;
      s1_in = a;
      s2_in = b;
      n = 0;
      while ({s1_ok, s2_ok} !== {a, b} && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk(n, 3);
      chk(s_change, 1'b1);
      @(negedge clk);
      chk(s_change, 1'b0);
   endtask

   // ====================================================================
   // Two frames back to back: second request while busy
   task automatic t_led(input logic [NB-1:0] a, input logic [NB-1:0] b);
      int n;
      led_state = a;
      led_update = 1'b1;
      @(negedge clk);
      led_update = 1'b0;
      repeat (2) @(negedge clk);
      chk(led_busy, 1'b1);
      repeat (20) @(negedge clk);
      led_state = b;
      led_update = 1'b1;
      @(negedge clk);
      led_update = 1'b0;
      n = 0;
      while (latch_count < 1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk(led_out, a);
      chk(bits_at_latch, NB);
      n = 0;
      while (latch_count < 2 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk(led_out, b);
      chk(bits_at_latch, 2 * `PSL_LED_PORTS);
      chk(clk_in_latch, 0);
      n = 0;
      while (led_busy !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk(led_sclk, 1'b0);
   endtask

   // ====================================================================
   // Main sequence and watchdog
   initial begin
      fail_count = 0;
      comparisons = 0;
      rst = 1'b1;
      led_state = '0;
      led_update = 1'b0;
      s1_in = 1'b0;
      s2_in = 1'b0;
      pse_cmd = 1'b0;
      @(negedge clk);
      t_reset();
      t_supply(1'b1, 1'b0);
      t_supply(1'b1, 1'b1);
      t_supply(1'b0, 1'b1);
      t_supply(1'b0, 1'b0);
      t_led(96'h8123_4567_89AB_CDEF_0F0F_F0F1, 96'h7EDC_BA98_7654_3210_F0F0_0F0E);
      t_pse_cmd();
      end_sim();
   end

   initial begin
      #500000;
      fail_count++;
      end_sim();
   end
endmodule
